//--- logic/ppl_params.svh
`ifndef PPL_PARAMS_SVH
`define PPL_PARAMS_SVH

// host register port geometry
`define PPL_ADDR_W 7
`define PPL_NUM_STAGES 8
`define PPL_NUM_DEST 4

// register offsets
`define PPL_OFS_GENERAL_CONFIG 7'h00
`define PPL_OFS_START_CONFIG 7'h02
`define PPL_OFS_GEAR_FACTOR 7'h12
`define PPL_OFS_POS_COMPARE 7'h32
`define PPL_OFS_TARGET_POS 7'h37
`define PPL_OFS_STAGE_FIRST 7'h38
`define PPL_OFS_STAGE_LAST 7'h3F
// stages occupy one aligned block of eight addresses
`define PPL_STAGE_BLOCK 4'h7

// field positions
`define PPL_FEED_SEL_LSB 12
`define PPL_FEED_SEL_W 4
`define PPL_STEP_SRC_LSB 1
`define PPL_STEP_SRC_W 2

// reset values
`define PPL_RST_WORD 32'h0000_0000
`define PPL_RST_MASK 8'h00

`endif

//--- logic/ppl_pkg.sv
package ppl_pkg;

  // destinations in feed-select bit order
  typedef enum logic [1:0] {
    PPL_DEST_TARGET  = 2'h0,
    PPL_DEST_POS_CMP = 2'h1,
    PPL_DEST_GEAR    = 2'h2,
    PPL_DEST_GENCONF = 2'h3
  } ppl_dest_t;

  typedef logic [3:0] ppl_feed_t;
  typedef logic [7:0] ppl_mask_t;
  typedef logic [2:0] ppl_stage_idx_t;

endpackage

//--- logic/ppl_map_if.sv
`timescale 1ns/1ps
interface ppl_map_if;
  import ppl_pkg::*;
  ppl_feed_t feed_sel;
  ppl_feed_t dest_en;
  ppl_stage_idx_t dest_src [4];
  ppl_dest_t stage_dest [8];
  logic [7:0] stage_in_seg;
  logic [7:0] stage_link;

  modport layout (
    input feed_sel,
    output dest_en, dest_src, stage_dest, stage_in_seg, stage_link
  );
  modport core (
    output feed_sel,
    input dest_en, dest_src, stage_dest, stage_in_seg, stage_link
  );
endinterface

//--- logic/ppl_layout.sv
`timescale 1ns/1ps
module ppl_layout (
  ppl_map_if.layout map // feed select in, segment layout out
);
  import ppl_pkg::*;

  function automatic logic [2:0] popc(input logic [3:0] v);
    popc = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // first stage of segment r when n destinations are fed
  function automatic logic [2:0] seg_start(input logic [2:0] n, input logic [1:0] r);
    case (n)
      3'h2: seg_start = {r[0], 2'h0};
      3'h3: seg_start = (r == 2'h0) ? 3'h0 : (r == 2'h1) ? 3'h3 : 3'h6;
      3'h4: seg_start = {r, 1'h0};
      default: seg_start = 3'h0;
    endcase
  endfunction

  // segment rank holding stage s
  function automatic logic [1:0] stage_rank(input logic [2:0] n, input logic [3:0] s);
    logic [1:0] rk;
    rk = 2'h0;
    for (int r = 1; r < 4; r++) begin
      if (3'(r) < n && {1'h0, seg_start(n, 2'(r))} <= s) begin
        rk = 2'(r);
      end
    end
    stage_rank = rk;
  endfunction

  // destination owning segment rank r
  function automatic ppl_dest_t rank_dest(input logic [3:0] f, input logic [1:0] r);
    ppl_dest_t d;
    d = PPL_DEST_TARGET;
    for (int i = 0; i < 4; i++) begin
      if (f[i] && popc(f & 4'((1 << i) - 1)) == {1'h0, r}) begin
        d = ppl_dest_t'(2'(i));
      end
    end
    rank_dest = d;
  endfunction

  wire logic [2:0] n_fed = popc(map.feed_sel); // R08

  assign map.dest_en = map.feed_sel; // R07

  for (genvar d = 0; d < 4; d++) begin : g_dest
    wire logic [1:0] rank = 2'(popc(map.feed_sel & 4'((1 << d) - 1)));
    assign map.dest_src[d] = seg_start(n_fed, rank); // R09 R10 R11
  end

  for (genvar s = 0; s < 8; s++) begin : g_stage
    wire logic [1:0] rk = stage_rank(n_fed, 4'(s));
    assign map.stage_in_seg[s] = (n_fed != 3'h0); // R08
    assign map.stage_dest[s] = rank_dest(map.feed_sel, rk); // R14
    if (s < 7) begin : g_lnk
      // a stage only pulls from its successor inside the same segment
      assign map.stage_link[s] = (n_fed != 3'h0) && (stage_rank(n_fed, 4'(s + 1)) == rk); // R15
    end else begin : g_end
      assign map.stage_link[s] = 1'b0; // R15
    end
  end
endmodule

//--- logic/ppl_pipeline.sv
`timescale 1ns/1ps
`include "ppl_params.svh"

// What this block does
// R01: single target feed loads target from stage 0
// R02: each stage takes its successor's value on start
// R03: all loads and shifts in one cycle
// R04: masked stages receive current destination value
// R05: eight stage registers at 0x38 to 0x3F
// R06: feeds target, compare, gear, general config
// R07: feed-select bit per destination enables feeding
// R08: set-bit count fixes segment layout
// R09: two destinations: stage 0 and stage 4
// R10: three destinations: stages 0, 3, 6
// R11: four destinations: stages 0, 2, 4, 6
// R12: software pipelines compare values when spaced tightly
// R13: pipelined config switches step input source
// R14: write-back value follows the segment's destination
// R15: shifting stays inside each segment
// R16: start is one-cycle pulse; idle means host only
module ppl_pipeline #(
  parameter int DATA_W = 32
) (
  input wire logic clock, // system clock, 125 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic reg_wr_en, // host register write strobe
  input wire logic reg_rd_en, // host register read strobe
  input wire logic [`PPL_ADDR_W-1:0] reg_addr, // host register address
  input wire logic [DATA_W-1:0] reg_wdata, // host write data
  input wire logic start_pulse, // internal start, one cycle
  input wire ppl_pkg::ppl_mask_t writeback_mask, // cyclic write-back stage select
  output logic [DATA_W-1:0] reg_rdata, // host read data
  output logic reg_rdata_valid, // read data strobe
  output logic [DATA_W-1:0] target_position, // target position register
  output logic [DATA_W-1:0] position_compare_value, // position compare register
  output logic [DATA_W-1:0] step_gear_factor, // gear factor register
  output logic [DATA_W-1:0] general_config, // general configuration register
  output logic [DATA_W-1:0] start_config, // start configuration register
  output logic [`PPL_STEP_SRC_W-1:0] step_input_source // step source field of general config
);
  import ppl_pkg::*;

  localparam int NS = `PPL_NUM_STAGES;
  localparam int ND = `PPL_NUM_DEST;

  if (DATA_W < `PPL_FEED_SEL_LSB + `PPL_FEED_SEL_W || DATA_W > 32) begin : g_bad_width
    $error("DATA_W must hold the feed-select field and be at most 32");
  end

  function automatic logic [`PPL_ADDR_W-1:0] dest_offset(input logic [1:0] d);
    case (d)
      2'h0: dest_offset = `PPL_OFS_TARGET_POS;
      2'h1: dest_offset = `PPL_OFS_POS_COMPARE;
      2'h2: dest_offset = `PPL_OFS_GEAR_FACTOR;
      default: dest_offset = `PPL_OFS_GENERAL_CONFIG;
    endcase
  endfunction

  logic [DATA_W-1:0] stage_q [NS];
  logic [DATA_W-1:0] stage_d [NS];
  logic [DATA_W-1:0] dest_q [ND];
  logic [DATA_W-1:0] dest_d [ND];
  logic [DATA_W-1:0] start_cfg_q;
  logic [DATA_W-1:0] rdata_q;
  logic rvalid_q;

  ppl_map_if map_if ();

  ppl_layout u_layout (
    .map(map_if.layout)
  );

  assign map_if.feed_sel = start_cfg_q[`PPL_FEED_SEL_LSB +: `PPL_FEED_SEL_W];

  // host address decode
  wire logic stage_hit = (reg_addr[`PPL_ADDR_W-1:3] == `PPL_STAGE_BLOCK); // R05
  wire logic [2:0] stage_sel = reg_addr[2:0];
  wire logic wr_start = reg_wr_en && (reg_addr == `PPL_OFS_START_CONFIG);
  logic [NS-1:0] wr_stage;
  logic [ND-1:0] wr_dest;

  // destinations: a host write in the same cycle as a start wins
  for (genvar d = 0; d < ND; d++) begin : g_dest
    assign wr_dest[d] = reg_wr_en && (reg_addr == dest_offset(2'(d))); // R06
    assign dest_d[d] = wr_dest[d] ? reg_wdata :
                       (start_pulse && map_if.dest_en[d]) ? stage_q[map_if.dest_src[d]] : // R01 R03 R07 R16
                       dest_q[d];
  end

  // stages: write-back beats shift, shift beats hold
  for (genvar s = 0; s < NS; s++) begin : g_stage
    wire logic do_wb = start_pulse && map_if.stage_in_seg[s] && writeback_mask[s]; // R04
    wire logic do_shift = start_pulse && map_if.stage_link[s]; // R02 R15
    assign wr_stage[s] = reg_wr_en && stage_hit && (stage_sel == 3'(s)); // R05
    if (s < NS - 1) begin : g_mid
      assign stage_d[s] = wr_stage[s] ? reg_wdata :
                          do_wb ? dest_q[map_if.stage_dest[s]] : // R14
                          do_shift ? stage_q[s+1] : // R02 R03
                          stage_q[s];
    end else begin : g_last
      // last stage has no successor; it keeps its value unless rewritten
      assign stage_d[s] = wr_stage[s] ? reg_wdata :
                          do_wb ? dest_q[map_if.stage_dest[s]] : // R14
                          stage_q[s]; // R15
    end
  end

  // read mux; unmapped addresses read zero
  wire logic [DATA_W-1:0] rd_mux =
    stage_hit ? stage_q[stage_sel] :
    (reg_addr == `PPL_OFS_START_CONFIG) ? start_cfg_q :
    (reg_addr == `PPL_OFS_TARGET_POS) ? dest_q[0] :
    (reg_addr == `PPL_OFS_POS_COMPARE) ? dest_q[1] :
    (reg_addr == `PPL_OFS_GEAR_FACTOR) ? dest_q[2] :
    (reg_addr == `PPL_OFS_GENERAL_CONFIG) ? dest_q[3] :
    DATA_W'(`PPL_RST_WORD);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        stage_q[i] <= DATA_W'(`PPL_RST_WORD);
      end
    end else begin
      stage_q <= stage_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ND; i++) begin
        dest_q[i] <= DATA_W'(`PPL_RST_WORD);
      end
    end else begin
      dest_q <= dest_d;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_cfg_q <= DATA_W'(`PPL_RST_WORD);
    end else if (wr_start) begin
      start_cfg_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= DATA_W'(`PPL_RST_WORD);
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= reg_rd_en ? rd_mux : rdata_q;
      rvalid_q <= reg_rd_en;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rdata_valid = rvalid_q;
  assign target_position = dest_q[0];
  assign position_compare_value = dest_q[1];
  assign step_gear_factor = dest_q[2];
  assign general_config = dest_q[3];
  assign start_config = start_cfg_q;
  // step source rides in general config, so it follows the pipeline
  assign step_input_source = dest_q[3][`PPL_STEP_SRC_LSB +: `PPL_STEP_SRC_W]; // R13

  // ---------------- assertions ----------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  wire logic [3:0] feed = map_if.feed_sel;
  wire logic no_host_wr = !reg_wr_en;

  sequence s_start_quiet(logic [3:0] f);
    start_pulse && no_host_wr && (feed == f);
  endsequence

  sequence s_idle_feed;
    (feed == 4'h0) && no_host_wr ##1 no_host_wr;
  endsequence

  a_single_target: assert property ( // R01
    s_start_quiet(4'h1) |=> target_position == $past(stage_q[0])
  ) else $error("target not loaded from stage 0");

  a_stage_shift: assert property ( // R02
    s_start_quiet(4'h1) ##0 !writeback_mask[0] |=> stage_q[0] == $past(stage_q[1])
  ) else $error("stage 0 did not take stage 1");

  a_one_cycle: assert property ( // R03
    s_start_quiet(4'hF) ##0 (writeback_mask == 8'h00) |=>
      (target_position == $past(stage_q[0])) && (stage_q[0] == $past(stage_q[1]))
      && (general_config == $past(stage_q[6])) && (stage_q[6] == $past(stage_q[7]))
  ) else $error("loads and shifts not in one cycle");

  a_writeback_loop: assert property ( // R04
    s_start_quiet(4'h1) ##0 writeback_mask[4] |=> stage_q[4] == $past(target_position)
  ) else $error("write-back to stage 4 missed");

  a_stage_window: assert property ( // R05
    reg_wr_en && reg_addr == `PPL_OFS_STAGE_LAST && !start_pulse |=> stage_q[7] == $past(reg_wdata)
  ) else $error("last stage write lost");

  a_host_dest: assert property ( // R06
    reg_wr_en && reg_addr == `PPL_OFS_GEAR_FACTOR |=> step_gear_factor == $past(reg_wdata)
  ) else $error("gear factor write lost");

  a_feed_gate: assert property ( // R07
    start_pulse && no_host_wr && !feed[2] |=> $stable(step_gear_factor)
  ) else $error("unfed destination changed");

  a_two_dest: assert property ( // R09
    s_start_quiet(4'h6) |=>
      (position_compare_value == $past(stage_q[0])) && (step_gear_factor == $past(stage_q[4]))
  ) else $error("two-segment mapping wrong");

  a_three_dest: assert property ( // R10
    s_start_quiet(4'hD) |=> (target_position == $past(stage_q[0]))
      && (step_gear_factor == $past(stage_q[3])) && (general_config == $past(stage_q[6]))
  ) else $error("three-segment mapping wrong");

  a_four_dest: assert property ( // R11
    s_start_quiet(4'hF) |=> (target_position == $past(stage_q[0]))
      && (position_compare_value == $past(stage_q[2])) && (step_gear_factor == $past(stage_q[4]))
      && (general_config == $past(stage_q[6]))
  ) else $error("four-segment mapping wrong");

  a_step_source: assert property ( // R13
    s_start_quiet(4'h8) |=>
      step_input_source == $past(stage_q[0][`PPL_STEP_SRC_LSB +: `PPL_STEP_SRC_W])
  ) else $error("step source not switched at start");

  a_wb_follows: assert property ( // R14
    s_start_quiet(4'h6) ##0 writeback_mask[7] |=> stage_q[7] == $past(step_gear_factor)
  ) else $error("write-back took wrong destination");

  a_seg_boundary: assert property ( // R15
    s_start_quiet(4'h6) ##0 !writeback_mask[3] |=> stage_q[3] == $past(stage_q[3])
  ) else $error("data crossed a segment boundary");

  a_idle_hold: assert property ( // R16
    (feed == 4'h0) && no_host_wr |=> $stable(target_position) && $stable(general_config)
  ) else $error("destination changed with feeding off");

  a_idle_stages: assert property ( // R08
    s_idle_feed |-> $stable(stage_q[0]) && $stable(stage_q[7])
  ) else $error("stages moved with no pipelining");

  // register port: one-cycle read answer, data held between reads
  sequence s_read(logic [`PPL_ADDR_W-1:0] a);
    reg_rd_en && (reg_addr == a);
  endsequence

  a_rd_strobe: assert property ( // R05
    reg_rd_en |=> reg_rdata_valid
  ) else $error("read strobe not answered");

  a_rd_quiet: assert property ( // R05
    !reg_rd_en |=> !reg_rdata_valid
  ) else $error("read valid without a read");

  a_rd_hold: assert property ( // R05
    !reg_rd_en |=> $stable(reg_rdata)
  ) else $error("read data moved between reads");

  a_rd_stage_first: assert property ( // R05
    s_read(`PPL_OFS_STAGE_FIRST) |=> reg_rdata == $past(stage_q[0])
  ) else $error("stage 0 read back wrong");

  a_rd_stage_last: assert property ( // R05
    s_read(`PPL_OFS_STAGE_LAST) |=> reg_rdata == $past(stage_q[7])
  ) else $error("stage 7 read back wrong");

  a_rd_target: assert property ( // R06
    s_read(`PPL_OFS_TARGET_POS) |=> reg_rdata == $past(target_position)
  ) else $error("target read back wrong");

  a_rd_general: assert property ( // R06
    s_read(`PPL_OFS_GENERAL_CONFIG) |=> reg_rdata == $past(general_config)
  ) else $error("general config read back wrong");

  a_rd_unmapped: assert property ( // R06
    s_read(7'h01) |=> reg_rdata == DATA_W'(`PPL_RST_WORD)
  ) else $error("unmapped address read nonzero");

  a_stage_write: assert property ( // R05
    reg_wr_en && (reg_addr == `PPL_OFS_STAGE_FIRST) |=> stage_q[0] == $past(reg_wdata)
  ) else $error("stage 0 write lost");

  a_stage_mid_write: assert property ( // R05
    reg_wr_en && (reg_addr == (`PPL_OFS_STAGE_FIRST + 7'h4)) |=> stage_q[4] == $past(reg_wdata)
  ) else $error("stage 4 write lost");

  // feed-select field only moves on its own write
  a_cfg_write: assert property ( // R08
    wr_start |=> start_config == $past(reg_wdata)
  ) else $error("start config write lost");

  a_cfg_hold: assert property ( // R08
    !wr_start |=> $stable(start_config)
  ) else $error("start config moved without a write");

  // unfed destinations stay put on a start
  a_target_gate: assert property ( // R07
    start_pulse && no_host_wr && !feed[0] |=> $stable(target_position)
  ) else $error("unfed target changed");

  a_compare_gate: assert property ( // R07
    start_pulse && no_host_wr && !feed[1] |=> $stable(position_compare_value)
  ) else $error("unfed compare value changed");

  a_general_gate: assert property ( // R07
    start_pulse && no_host_wr && !feed[3] |=> $stable(general_config)
  ) else $error("unfed general config changed");

  // shift and hold inside each layout
  a_single_last: assert property ( // R15
    s_start_quiet(4'h1) ##0 !writeback_mask[7] |=> stage_q[7] == $past(stage_q[7])
  ) else $error("single segment tail moved");

  a_two_shift: assert property ( // R02
    s_start_quiet(4'h6) ##0 !writeback_mask[4] |=> stage_q[4] == $past(stage_q[5])
  ) else $error("upper half did not shift");

  a_three_shift: assert property ( // R02
    s_start_quiet(4'hD) ##0 !writeback_mask[3] |=> stage_q[3] == $past(stage_q[4])
  ) else $error("middle segment did not shift");

  a_three_hold: assert property ( // R15
    s_start_quiet(4'hD) ##0 !writeback_mask[5] |=> stage_q[5] == $past(stage_q[5])
  ) else $error("middle segment tail moved");

  a_four_shift: assert property ( // R02
    s_start_quiet(4'hF) ##0 !writeback_mask[4] |=> stage_q[4] == $past(stage_q[5])
  ) else $error("pair segment did not shift");

  a_four_hold: assert property ( // R15
    s_start_quiet(4'hF) ##0 !writeback_mask[1] |=> stage_q[1] == $past(stage_q[1])
  ) else $error("pair segment tail moved");

  // with feeding off a start touches nothing
  a_idle_mid: assert property ( // R16
    s_idle_feed |-> $stable(stage_q[3]) && $stable(stage_q[4])
  ) else $error("middle stages moved with no pipelining");

  a_idle_compare: assert property ( // R16
    (feed == 4'h0) && no_host_wr |=> $stable(position_compare_value) && $stable(step_gear_factor)
  ) else $error("compare or gear changed with feeding off");

endmodule

//--- tb/ppl_host.sv
`timescale 1ns/1ps
module ppl_host (
  input wire logic clock, // system clock
  input wire logic [31:0] reg_rdata, // read data from device
  input wire logic reg_rdata_valid, // read data strobe
  output logic reg_wr_en, // write strobe
  output logic reg_rd_en, // read strobe
  output logic [6:0] reg_addr, // register address
  output logic [31:0] reg_wdata // write data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 7'h7F;
    reg_wdata = 32'h0000_0000;
  end

  // released data carries the inverse so a stale word never looks fresh
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = 32'h0000_0000;
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (reg_rdata_valid === 1'b1) begin
        d = reg_rdata;
        ok = 1'b1;
      end else @(posedge clock);
    end
  endtask
endmodule

//--- tb/tb_ppl_pipeline.sv
`timescale 1ns/1ps
`include "ppl_params.svh"
module tb_ppl_pipeline;
  import ppl_pkg::*;
  logic clock;
  logic rst_n;
  logic start_pulse;
  ppl_mask_t writeback_mask;
  logic reg_wr_en, reg_rd_en, reg_rdata_valid;
  logic [6:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, tgt, cmp, gear, gcfg, scfg;
  logic [1:0] src;
  int n_mismatch = 0;
  int total_checks = 0;

  ppl_pipeline ppl_pipeline_inst (.clock(clock), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .start_pulse(start_pulse), .writeback_mask(writeback_mask),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .target_position(tgt),
    .position_compare_value(cmp), .step_gear_factor(gear), .general_config(gcfg), .start_config(scfg),
    .step_input_source(src));
  ppl_host ppl_host_inst (.clock(clock), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdchk(input string what, input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    ppl_host_inst.rd(a, d, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %s expected read strobe seen none", what);
      stop_test();
    end else begin
      chk(what, exp, d);
    end
  endtask

  // stage i gets b+i so every stage is told apart after a shift
  task automatic load(input logic [31:0] b, input ppl_feed_t f, input ppl_mask_t m);
    for (int i = 0; i < 8; i++) ppl_host_inst.wr(`PPL_OFS_STAGE_FIRST + 7'(i), b + 32'(i));
    ppl_host_inst.wr(`PPL_OFS_START_CONFIG, {16'h0000, f, 12'h000});
    @(posedge clock);
    writeback_mask <= m;
  endtask

  task automatic fire;
    @(posedge clock);
    start_pulse <= 1'b1;
    @(posedge clock);
    start_pulse <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    chk("target", 32'h0, tgt);
    chk("general", 32'h0, gcfg);
    chk("start cfg", 32'h0, scfg);
    rdchk("unmapped", 7'h01, 32'h0);
  endtask

  task automatic t_target;
    load(32'h1000_0000, 4'h1, 8'h00);
    rdchk("stage7 addr", `PPL_OFS_STAGE_LAST, 32'h1000_0007);
    fire();
    chk("target", 32'h1000_0000, tgt);
    chk("compare", 32'h0, cmp);
    for (int i = 0; i < 7; i++) rdchk("stage", `PPL_OFS_STAGE_FIRST + 7'(i), 32'h1000_0001 + 32'(i));
    rdchk("stage7", `PPL_OFS_STAGE_LAST, 32'h1000_0007);
  endtask

  task automatic t_writeback;
    load(32'h2000_0000, 4'h1, 8'h10);
    fire();
    chk("target", 32'h2000_0000, tgt);
    rdchk("stage4", `PPL_OFS_STAGE_FIRST + 7'd4, 32'h1000_0000);
    rdchk("stage3", `PPL_OFS_STAGE_FIRST + 7'd3, 32'h2000_0004);
  endtask

  // gear factor queued ahead so write-back carries it into stage 7 on the start edge
  task automatic t_two;
    ppl_host_inst.wr(`PPL_OFS_GEAR_FACTOR, 32'h5A5A_0000);
    load(32'h3000_0000, 4'h6, 8'h80);
    fire();
    chk("compare", 32'h3000_0000, cmp);
    chk("gear", 32'h3000_0004, gear);
    chk("target", 32'h2000_0000, tgt);
    rdchk("stage3", `PPL_OFS_STAGE_FIRST + 7'd3, 32'h3000_0003);
    rdchk("stage7", `PPL_OFS_STAGE_LAST, 32'h5A5A_0000);
  endtask

  task automatic t_three;
    load(32'h4000_0000, 4'hD, 8'h00);
    fire();
    chk("target", 32'h4000_0000, tgt);
    chk("gear", 32'h4000_0003, gear);
    chk("general", 32'h4000_0006, gcfg);
    chk("compare", 32'h3000_0000, cmp);
    rdchk("stage2", `PPL_OFS_STAGE_FIRST + 7'd2, 32'h4000_0002);
    rdchk("stage5", `PPL_OFS_STAGE_FIRST + 7'd5, 32'h4000_0005);
  endtask

  task automatic t_four;
    load(32'h5000_0000, 4'hF, 8'h00);
    fire();
    chk("target", 32'h5000_0000, tgt);
    chk("compare", 32'h5000_0002, cmp);
    chk("gear", 32'h5000_0004, gear);
    chk("general", 32'h5000_0006, gcfg);
    rdchk("stage0", `PPL_OFS_STAGE_FIRST, 32'h5000_0001);
    rdchk("stage1", `PPL_OFS_STAGE_FIRST + 7'd1, 32'h5000_0001);
    chk("start cfg", 32'h0000_F000, scfg);
    rdchk("target rd", `PPL_OFS_TARGET_POS, 32'h5000_0000);
    rdchk("general rd", `PPL_OFS_GENERAL_CONFIG, 32'h5000_0006);
  endtask

  // stage1 holds 1 in bit 0 only, so its source field reads as ramp
  task automatic t_source;
    load(32'h7000_0000, 4'h8, 8'h00);
    ppl_host_inst.wr(`PPL_OFS_STAGE_FIRST, 32'h7000_0002);
    fire();
    chk("source ext", 32'h1, {30'h0, src});
    chk("general", 32'h7000_0002, gcfg);
    fire();
    chk("source ramp", 32'h0, {30'h0, src});
  endtask

  task automatic t_idle;
    load(32'h8000_0000, 4'h0, 8'hFF);
    fire();
    chk("target", 32'h5000_0000, tgt);
    chk("general", 32'h7000_0001, gcfg);
    rdchk("stage0", `PPL_OFS_STAGE_FIRST, 32'h8000_0000);
  endtask

  initial begin
    rst_n = 1'b0;
    start_pulse = 1'b0;
    writeback_mask = 8'h00;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    t_reset();
    t_target();
    t_writeback();
    t_two();
    t_three();
    t_four();
    t_source();
    t_idle();
    stop_test();
  end
endmodule
